// [pmc_params.svh]
// Operation
// RULE1: One 8-bit register at A2h, resets zero
// RULE2: Bits 6:5 select PLL lock wait time
// RULE3: Firmware sets lock time before deep idle
// RULE4: Reset button press sets bit 4
// RULE5: Firmware reads and clears reset-button flag
// RULE6: Resume reset and CF9h reset clear flags; code clears only bits 4 and 3
// RULE7: Thermal trip in working states sets bit 3
// RULE8: Thermal flag survives its own shutdown reboot
// RULE9: Regulator low sets bit 1 outside exemptions
// RULE10: Power-good low sets bit 0, G3 clears; code sets it only in working states
// RULE11: Regulator good sampled on real-time clock
// RULE12: Write one clears; set beats clear
// RULE13: Reserved bits 7 and 2 read zero
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
// Register indices: each register is one word at four times its index
`define PMC_ADDR_CFG      8'hA2
`define PMC_ADDR_IRQ_STS  8'hA4
`define PMC_ADDR_IRQ_MASK 8'hA8
`define PMC_RESET_VAL     8'h00
`define PMC_BIT_POWER_GOOD     0
`define PMC_BIT_CPUPWR    1
`define PMC_BIT_THERM     3
`define PMC_BIT_RSTBTN    4
`define PMC_LOCK_LSB      5
`define PMC_LOCK_MSB      6
`define PMC_RW_MASK       8'h60
`define PMC_FLAG_MASK     8'h1B
`define PMC_LOCK_NS_0     30700
`define PMC_LOCK_NS_1     61400
`define PMC_LOCK_NS_2     122800
`define PMC_LOCK_NS_3     245600
`define PMC_CLK_NS        8
`define PMC_HTRANS_NONSEQ 2'h2
`endif

// [pmc_pins.sv]
`timescale 1ns/100ps
`default_nettype none
module pmc_pins #(
    parameter int HALF = 20
) (
    output logic rtc_clk
);
    // Slow clock so that short regulator dips really can be missed
    logic clk_r = 1'b0;
    assign rtc_clk = clk_r;
    always #(HALF) clk_r = ~clk_r;
endmodule : pmc_pins
`default_nettype wire

// [pmc_pkg.sv]
package pmc_pkg;
    typedef struct packed {
        logic working;
        logic light_sleep;
        logic perf_transition;
        logic deeper_idle_seq;
        logic deep_sleep_en;
        logic light_sleep_seq;
        logic mech_off;
        logic cf9_reset;
    } pmc_sys_s;
    typedef enum logic [1:0] {
        PMC_IDLE = 2'b00,
        PMC_WR   = 2'b01,
        PMC_RD   = 2'b10
    } pmc_bus_e;
endpackage : pmc_pkg

// [pmc_regs.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pmc_params.svh"
module pmc_regs (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic             reset_button_n,
    input  wire logic             cpu_overheat_n,
    input  wire logic             platform_reset_n,
    input  wire logic             resume_well_reset_n,
    input  wire logic             power_good,
    input  wire logic             rtc_clk,
    input  wire logic             regulator_good,
    input  wire pmc_pkg::pmc_sys_s sys_state,
    output logic      [1:0]       pll_lock_time_sel,
    output logic      [31:0]      pll_lock_cycles,
    output logic                  irq
);
    localparam logic [31:0] LOCK0 = 32'((`PMC_LOCK_NS_0 + `PMC_CLK_NS - 1)
                                        / `PMC_CLK_NS);
    localparam logic [31:0] LOCK1 = 32'((`PMC_LOCK_NS_1 + `PMC_CLK_NS - 1)
                                        / `PMC_CLK_NS);
    localparam logic [31:0] LOCK2 = 32'((`PMC_LOCK_NS_2 + `PMC_CLK_NS - 1)
                                        / `PMC_CLK_NS);
    localparam logic [31:0] LOCK3 = 32'((`PMC_LOCK_NS_3 + `PMC_CLK_NS - 1)
                                        / `PMC_CLK_NS);

    // Level inputs from pins, synchronised before use
    logic [4:0] pin_s;
    pmc_sync #(.W(5)) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({reset_button_n, cpu_overheat_n, platform_reset_n,
                 resume_well_reset_n, power_good}),
        .q     (pin_s)
    );

    // Regulator good is first caught on the slow real-time clock; short
    // lows can be missed, which is accepted behaviour.
    logic rtc_vg_r;
    always_ff @(posedge rtc_clk or negedge hresetn) begin
        if (!hresetn) begin
            rtc_vg_r <= 1'b1;
        end else begin
            rtc_vg_r <= regulator_good; // see RULE11
        end
    end
    logic vg_s;
    pmc_sync #(.W(1)) u_sync_vg (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (rtc_vg_r),
        .q     (vg_s)
    );

    function automatic logic [31:0] lock_cycles(input logic [1:0] sel);
        logic [31:0] c;
        c = LOCK0;
        unique case (sel)
            2'b00: c = LOCK0;
            2'b01: c = LOCK1;
            2'b10: c = LOCK2;
            2'b11: c = LOCK3;
        endcase
        return c;
    endfunction : lock_cycles

    // Registers are decoded by index; the byte address is four times it
    function automatic logic [7:0] word_addr(input logic [31:0] a);
        return a[9:2];
    endfunction : word_addr

    // Clear before set, so an event in the clearing cycle is not lost
    function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                             input logic [7:0] clr,
                                             input logic [7:0] set);
        return ((cur & ~clr) | set) & `PMC_FLAG_MASK;
    endfunction : flag_next

    // The lock field must stay two bits wide to match the select port
    if (`PMC_LOCK_MSB - `PMC_LOCK_LSB != 1) begin : g_lock_check
        $error("lock field must be two bits wide");
    end

    logic [7:0]        cfg_r;
    logic [7:0]        cfg_nxt;
    logic [7:0]        isr_r;
    logic [7:0]        isr_nxt;
    logic [7:0]        imask_r;
    logic [7:0]        imask_nxt;
    logic [4:0]        prev_r;
    logic [4:0]        prev_nxt;
    logic              vg_prev_r;
    logic              vg_prev_nxt;
    pmc_pkg::pmc_bus_e ph_r;
    pmc_pkg::pmc_bus_e ph_nxt;
    logic [7:0]        ph_addr_r;
    logic [7:0]        ph_addr_nxt;
    logic [31:0]       hrdata_nxt;
    logic              irq_nxt;
    logic [1:0]        lts_nxt;
    logic [31:0]       plc_nxt;

    logic              btn_n;
    logic              trip_n;
    logic              prst_n;
    logic              rsm_n;
    logic              pgood;
    logic              in_work;
    logic              vg_exempt;
    logic [7:0]        set_v;
    logic [7:0]        clr_v;
    logic [7:0]        sw_clr;
    logic [7:0]        isr_clr;

    // Pin events: every pin idles high, so a fall is the event
    always_comb begin
        {btn_n, trip_n, prst_n, rsm_n, pgood} = pin_s;
        in_work     = sys_state.working | sys_state.light_sleep;
        vg_exempt   = sys_state.perf_transition | sys_state.deeper_idle_seq |
                      (sys_state.light_sleep_seq & sys_state.deep_sleep_en);
        set_v       = 8'h00;
        set_v[`PMC_BIT_RSTBTN] = prev_r[4] & ~btn_n; // see RULE4
        set_v[`PMC_BIT_THERM]  = prev_r[3] & ~trip_n & prst_n &
                                 in_work; // see RULE7
        set_v[`PMC_BIT_CPUPWR] = vg_prev_r & ~vg_s & ~vg_exempt; // see RULE9
        set_v[`PMC_BIT_POWER_GOOD]  = prev_r[0] & ~pgood & in_work; // see RULE10
        prev_nxt    = pin_s;
        vg_prev_nxt = vg_s;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r    <= '1;
            vg_prev_r <= 1'b1;
        end else begin
            prev_r    <= prev_nxt;
            vg_prev_r <= vg_prev_nxt;
        end
    end

    // Address phase is taken when selected, ready and NONSEQ
    always_comb begin
        ph_nxt      = pmc_pkg::PMC_IDLE;
        ph_addr_nxt = ph_addr_r;
        if (hsel && hready && htrans == `PMC_HTRANS_NONSEQ) begin
            ph_nxt      = hwrite ? pmc_pkg::PMC_WR : pmc_pkg::PMC_RD;
            ph_addr_nxt = word_addr(haddr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_r      <= pmc_pkg::PMC_IDLE;
            ph_addr_r <= 8'h00;
        end else begin
            ph_r      <= ph_nxt;
            ph_addr_r <= ph_addr_nxt;
        end
    end

    // Config register: lock field written, flags cleared by one
    always_comb begin
        cfg_nxt = cfg_r;
        sw_clr  = 8'h00;
        if (ph_r == pmc_pkg::PMC_WR && ph_addr_r == `PMC_ADDR_CFG) begin
            cfg_nxt = (cfg_r & ~`PMC_RW_MASK) |
                      (hwdata[7:0] & `PMC_RW_MASK); // see RULE2
            sw_clr  = hwdata[7:0]; // see RULE12
        end
        clr_v = sw_clr;
        // Thermal shutdown/reboot only drops platform reset: flag holds
        if (!rsm_n || sys_state.cf9_reset) begin
            clr_v[`PMC_BIT_RSTBTN] = 1'b1; // see RULE6
            clr_v[`PMC_BIT_THERM]  = 1'b1; // see RULE6
        end
        if (sys_state.mech_off) begin
            clr_v[`PMC_BIT_POWER_GOOD] = 1'b1; // see RULE10
        end
        cfg_nxt = (cfg_nxt & `PMC_RW_MASK) |
                  flag_next(cfg_r, clr_v, set_v); // see RULE8, RULE13
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r <= `PMC_RESET_VAL; // see RULE1
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // Interrupt status takes the same events; the mask picks what raises irq
    always_comb begin
        imask_nxt = imask_r;
        isr_clr   = 8'h00;
        if (ph_r == pmc_pkg::PMC_WR) begin
            if (ph_addr_r == `PMC_ADDR_IRQ_STS) begin
                isr_clr = hwdata[7:0];
            end
            if (ph_addr_r == `PMC_ADDR_IRQ_MASK) begin
                imask_nxt = hwdata[7:0] & `PMC_FLAG_MASK;
            end
        end
        isr_nxt = flag_next(isr_r, isr_clr, set_v); // see RULE12
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            isr_r   <= 8'h00;
            imask_r <= 8'h00;
        end else begin
            isr_r   <= isr_nxt;
            imask_r <= imask_nxt;
        end
    end

    // Read data uses the next values, so a read sees this cycle's write
    always_comb begin
        hrdata_nxt = 32'h0;
        if (ph_nxt == pmc_pkg::PMC_RD) begin
            unique case (ph_addr_nxt)
                `PMC_ADDR_CFG:      hrdata_nxt = {24'h0, cfg_nxt}; // see RULE1
                `PMC_ADDR_IRQ_STS:  hrdata_nxt = {24'h0, isr_nxt};
                `PMC_ADDR_IRQ_MASK: hrdata_nxt = {24'h0, imask_nxt};
                default:            hrdata_nxt = 32'h0; // see RULE13
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else begin
            hrdata <= hrdata_nxt;
        end
    end

    // Outputs follow the next values, so they line up with the register
    always_comb begin
        irq_nxt = |(isr_nxt & imask_nxt);
        lts_nxt = cfg_nxt[`PMC_LOCK_MSB:`PMC_LOCK_LSB];
        plc_nxt = lock_cycles(lts_nxt); // see RULE2
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq               <= 1'b0;
            pll_lock_time_sel <= 2'b00;
            pll_lock_cycles   <= LOCK0;
        end else begin
            irq               <= irq_nxt;
            pll_lock_time_sel <= lts_nxt;
            pll_lock_cycles   <= plc_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
endmodule : pmc_regs
`default_nettype wire

// [pmc_regs_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pmc_params.svh"
module pmc_regs_sva (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic              resume_well_reset_n,
    input wire pmc_pkg::pmc_sys_s sys_state,
    input wire logic [1:0]        pll_lock_time_sel,
    input wire logic [31:0]       pll_lock_cycles,
    input wire logic              irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        tk, rc, wc, um, clr;
    logic [31:0] cyc_exp;
    assign tk  = hsel && hready && htrans == `PMC_HTRANS_NONSEQ;
    assign rc  = tk && !hwrite && haddr[9:2] == `PMC_ADDR_CFG;
    assign wc  = tk && hwrite && haddr[9:2] == `PMC_ADDR_CFG;
    assign um  = !(haddr[9:2] inside {`PMC_ADDR_CFG, `PMC_ADDR_IRQ_STS,
                                      `PMC_ADDR_IRQ_MASK});
    assign clr = !resume_well_reset_n || sys_state.cf9_reset;
    // Rounded up to whole clock periods, so the wait is never short
    assign cyc_exp = 32'(((`PMC_LOCK_NS_0 << pll_lock_time_sel)
                          + `PMC_CLK_NS - 1) / `PMC_CLK_NS);
    property p_sel;
        logic [1:0] v;
        wc ##1 (1'b1, v = hwdata[6:5]) |-> ##[1:2] pll_lock_time_sel == v;
    endproperty
    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_rsvd_zero: assert property (
        hrdata[31:8] == 0 && !hrdata[7] && !hrdata[2])
        else $error("reserved read bits set");
    a_idle_zero: assert property (
        !$past(tk && !hwrite) |-> hrdata == 0)
        else $error("read data outside read");
    a_unmapped_zero: assert property (
        tk && !hwrite && um |=> hrdata == 0)
        else $error("unmapped read not zero");
    a_sel_write: assert property (p_sel)
        else $error("lock select not written");
    a_cycles_map: assert property (pll_lock_cycles == cyc_exp)
        else $error("lock cycles wrong");
    a_flags_clear: assert property (
        clr [*4] ##0 rc |=> hrdata[4:3] == 0)
        else $error("flags not cleared by reset");
    a_g3_clear: assert property (
        sys_state.mech_off [*4] ##0 rc |=> !hrdata[0])
        else $error("power good flag kept in off state");
    c_rd_cfg: cover property (rc);
    c_wr_cfg: cover property (wc);
    c_irq: cover property ($rose(irq));
endmodule : pmc_regs_sva
bind pmc_regs pmc_regs_sva u_sva (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hwdata              (hwdata),
    .hready              (hready),
    .hrdata              (hrdata),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .resume_well_reset_n (resume_well_reset_n),
    .sys_state           (sys_state),
    .pll_lock_time_sel   (pll_lock_time_sel),
    .pll_lock_cycles     (pll_lock_cycles),
    .irq                 (irq)
);
`default_nettype wire

// [pmc_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module pmc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s1_nxt;
    logic [W-1:0] q_nxt;
    always_comb begin
        s1_nxt = d;
        q_nxt  = s1_r;
    end
    // Inputs idle high so reset to ones avoids false edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '1;
            q    <= '1;
        end else begin
            s1_r <= s1_nxt;
            q    <= q_nxt;
        end
    end
endmodule : pmc_sync
`default_nettype wire

// [test_pmc_regs.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pmc_params.svh"
module test_pmc_regs;
    logic              hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic              rtc, irq, hrdy, hresp, plat = 1, rsm = 1;
    logic [31:0]       haddr = '0, hwdata = '0, hrdata, cyc, r, b;
    logic [31:0]       x = 32'hE38A204C;
    logic [1:0]        htrans = 2'h0, sel, lk;
    logic [3:0]        pn = 4'hF;
    logic [31:0]       fb [4] = '{32'h02, 32'h01, 32'h08, 32'h10};
    pmc_pkg::pmc_sys_s sy = 8'h80;
    int                n_fail = 0, n_tests = 0;
    always #4 hclk = ~hclk;
    pmc_pins u_pins (.rtc_clk(rtc));
    pmc_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
        .reset_button_n(pn[3]), .cpu_overheat_n(pn[2]),
        .platform_reset_n(plat), .resume_well_reset_n(rsm),
        .power_good(pn[1]), .rtc_clk(rtc), .regulator_good(pn[0]),
        .sys_state(sy), .pll_lock_time_sel(sel), .pll_lock_cycles(cyc),
        .irq(irq));
    function logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    task close_out;
        if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            $display("BAD %0t %h %h", $time, g, e);
            n_fail++;
        end
    endtask : chk
    task wt;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        if (hrdy !== 1'b1) begin
            n_fail++;
            close_out;
        end
    endtask : wt
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, a, 2'b00};
        wt;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt;
        r = hrdata;
    endtask : ahb
    task rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(r, e);
    endtask : rd
    // Pins held long enough to span several slow-clock periods
    task p(input int i);
        pn[i] <= 1'b0;
        repeat (30) @(posedge hclk);
        pn[i] <= 1'b1;
        repeat (30) @(posedge hclk);
    endtask : p
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`PMC_ADDR_CFG, 32'h0);
        rd(`PMC_ADDR_IRQ_STS, 32'h0);
        rd(`PMC_ADDR_IRQ_MASK, 32'h0);
        chk(irq, 32'h0);
        for (int k = 0; k < 4; k++) begin
            x = xs(x);
            lk = k[1:0];
            ahb(1'b1, `PMC_ADDR_CFG, {x[31:7], lk, x[4:0]});
            rd(`PMC_ADDR_CFG, {25'h0, lk, 5'h0});
            repeat (2) @(posedge hclk);
            chk(sel, {30'h0, lk});
            chk(cyc, ((`PMC_LOCK_NS_0 << k) + 7) / 8);
        end
        b = {25'h0, lk, 5'h0};
        ahb(1'b1, `PMC_ADDR_IRQ_MASK, {24'h0, `PMC_FLAG_MASK});
        sy.perf_transition <= 1'b1;
        p(0);
        sy.perf_transition <= 1'b0;
        rd(`PMC_ADDR_CFG, b);
        for (int i = 0; i < 4; i++) begin
            p(i);
            rd(`PMC_ADDR_CFG, b | fb[i]);
            chk(irq, 32'h1);
            ahb(1'b1, `PMC_ADDR_CFG, b);
            rd(`PMC_ADDR_CFG, b | fb[i]);
            ahb(1'b1, `PMC_ADDR_CFG, b | fb[i]);
            rd(`PMC_ADDR_CFG, b);
            ahb(1'b1, `PMC_ADDR_IRQ_STS, fb[i]);
            repeat (2) @(posedge hclk);
            chk(irq, 32'h0);
        end
        p(1);
        sy.mech_off <= 1'b1;
        repeat (5) @(posedge hclk);
        rd(`PMC_ADDR_CFG, b);
        sy.mech_off <= 1'b0;
        ahb(1'b1, `PMC_ADDR_IRQ_MASK, 32'h0);
        p(3);
        p(2);
        chk(irq, 32'h0);
        plat <= 1'b0;
        repeat (5) @(posedge hclk);
        plat <= 1'b1;
        rd(`PMC_ADDR_CFG, b | 32'h18);
        rsm <= 1'b0;
        repeat (5) @(posedge hclk);
        rd(`PMC_ADDR_CFG, b);
        rsm <= 1'b1;
        p(2);
        sy.cf9_reset <= 1'b1;
        repeat (5) @(posedge hclk);
        rd(`PMC_ADDR_CFG, b);
        sy.cf9_reset <= 1'b0;
        ahb(1'b1, 8'hB0, 32'hFF);
        rd(8'hB0, 32'h0);
        close_out;
    end
    initial begin
        #400000;
        n_fail++;
        close_out;
    end
endmodule : test_pmc_regs
`default_nettype wire
